// >>> tmrso_pkg.sv
package tmrso_pkg;
  // register indexes on the plain port (no offsets printed for this block)
  localparam logic [3:0] ADDR_TCTL0 = 4'h0;
  localparam logic [3:0] ADDR_TCTL1 = 4'h1;
  localparam logic [3:0] ADDR_TSC0 = 4'h2;
  localparam logic [3:0] ADDR_TSC1 = 4'h3;
  localparam logic [3:0] ADDR_TCA0 = 4'h4;
  localparam logic [3:0] ADDR_TCA1 = 4'h5;
  localparam logic [3:0] ADDR_TCB0 = 4'h6;
  localparam logic [3:0] ADDR_TCB1 = 4'h7;
  localparam logic [3:0] ADDR_CNT0 = 4'h8;
  localparam logic [3:0] ADDR_CNT1 = 4'h9;
  localparam logic [3:0] ADDR_MSTP_HI = 4'hA;
  localparam logic [3:0] ADDR_MSTP_LO = 4'hB;
  // status/control field positions
  localparam int BIT_COMPARE_B_FLAG = 7;
  localparam int BIT_COMPARE_A_FLAG = 6;
  localparam int BIT_OVF = 5;
  localparam int BIT_ADC_TRIGGER_ENABLE = 4;
  // timer control field positions; BIT_STOP is in the module stop register
  localparam int BIT_IEB = 7;
  localparam int BIT_IEA = 6;
  localparam int BIT_IEO = 5;
  localparam int BIT_STOP = 12;
  // reset values
  localparam logic [7:0] RST_TSC0 = 8'h00;
  localparam logic [7:0] RST_TSC1 = 8'h10;
  localparam logic [7:0] RST_TC = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [15:0] RST_MSTP = 16'h3FFF;
  // prescaler divide ratios
  localparam int DIV_A = 8;
  localparam int DIV_B = 64;
  localparam int DIV_C = 8192;
  localparam int PRE_W = 13;
  // clock select codes
  localparam logic [2:0] CKS_OFF = 3'h0;
  localparam logic [2:0] CKS_D8 = 3'h1;
  localparam logic [2:0] CKS_D64 = 3'h2;
  localparam logic [2:0] CKS_D8192 = 3'h3;
  localparam logic [2:0] CKS_CASC = 3'h4;
  localparam logic [2:0] CKS_EXT_R = 3'h5;
  localparam logic [2:0] CKS_EXT_F = 3'h6;
  localparam logic [2:0] CKS_EXT_B = 3'h7;
  // output select actions
  localparam logic [1:0] OS_KEEP = 2'h0;
  localparam logic [1:0] OS_LOW = 2'h1;
  localparam logic [1:0] OS_HIGH = 2'h2;
  localparam logic [1:0] OS_TOG = 2'h3;
endpackage

// >>> tmrso_chan.sv
`timescale 1ns/100ps
`default_nettype none
module tmrso_chan (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  input wire logic [7:0] tconst_a,
  input wire logic [7:0] tconst_b,
  input wire logic cnt_we,
  input wire logic [7:0] cnt_wdata,
  input wire logic [3:0] out_sel,
  output logic [7:0] timer_count,
  output logic match_a,
  output logic match_b,
  output logic ovf_evt,
  output logic timer_out
);
  import tmrso_pkg::*;
  logic [7:0] count_r;
  logic out_r;
  logic act_a;
  logic act_b;
  logic [1:0] eff;

  // match is signalled on the pulse that leaves the equal value
  assign match_a = run && tick && (count_r == tconst_a); // [R5] [R20]
  assign match_b = run && tick && (count_r == tconst_b); // [R5] [R20]
  assign ovf_evt = run && tick && (count_r == 8'hFF); // [R6]
  assign timer_count = count_r;
  assign timer_out = out_r;

  // counter; a software write wins over an increment
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_r <= RST_ZERO;
    end else if (cnt_we) begin
      count_r <= cnt_wdata;
    end else if (run && tick) begin
      count_r <= count_r + 8'h01; // [R21]
    end
  end

  // higher code ranks higher: toggle > 1 > 0 > keep
  always_comb begin
    act_a = match_a && (out_sel[1:0] != OS_KEEP); // [R10]
    act_b = match_b && (out_sel[3:2] != OS_KEEP); // [R9]
    eff = OS_KEEP;
    if (act_a && act_b) begin
      eff = (out_sel[1:0] > out_sel[3:2]) ? out_sel[1:0] : out_sel[3:2]; // [R11]
    end else if (act_a) begin
      eff = out_sel[1:0];
    end else if (act_b) begin
      eff = out_sel[3:2];
    end
  end

  // output level; all-zero select leaves it frozen
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_r <= 1'b0; // [R13]
    end else if (out_sel != 4'h0) begin // [R12]
      case (eff)
        OS_LOW: out_r <= 1'b0;
        OS_HIGH: out_r <= 1'b1;
        OS_TOG: out_r <= ~out_r;
        default: out_r <= out_r;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tmrso_top.sv
// Function
// R1 - status flags accept only a written 0, which clears them; 1 is ignored
// R2 - after reset channel 0 status is 0x00, channel 1 status is 0x10
// R3 - a flag clears only if a read saw it 1 before the 0 write
// R4 - compare flags also clear when transfer controller serves them with select 0
// R5 - compare flag A/B sets when counter equals constant A/B
// R6 - overflow flag sets when counter wraps from FF to 00
// R7 - channel 0 bit 4 enables A/D start on compare match A
// R8 - channel 1 bit 4 reads 1 and ignores writes
// R9 - bits 3:2 pick match B output action: keep, 0, 1, toggle
// R10 - bits 1:0 pick match A output action independently
// R11 - simultaneous matches follow toggle over 1 over 0
// R12 - all four select bits 0 disables the timer output
// R13 - timer output is 0 after reset until first match changes it
// R14 - module stop bit 12 set halts the timer; clearing it resumes
// R15 - registers do not respond while in module stop mode
// R16 - module stop register resets to 0x3FFF, timer starts stopped
// R17 - internal sources are clock divided by 8, 64 and 8192
// R18 - external input counts on rising, falling or both edges
// R19 - external levels must last 1.5 states single edge, 2.5 both
// R20 - match is signalled on the pulse leaving the equal count
// R21 - each counter is 8-bit and increments on each selected pulse
// R22 - clock select: off, three dividers, cascade, three external modes
// R23 - interrupt request only while flag and its enable are both 1
// R24 - a hardware set wins over a same-cycle clearing write
// R25 - A/D start request is a one-cycle pulse at match A
`timescale 1ns/100ps
`default_nettype none
module tmrso_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic ext_clk_in,
  input wire logic [1:0] dtc_ack_a,
  input wire logic [1:0] dtc_ack_b,
  input wire logic [1:0] transfer_irq_select,
  output logic [1:0] timer_out,
  output logic adc_start,
  output logic [1:0] compare_a_irq,
  output logic [1:0] compare_b_irq,
  output logic [1:0] overflow_irq
);
  import tmrso_pkg::*;

  typedef enum logic [1:0] {
    TMRSO_RUN = 2'b01,
    TMRSO_STOP = 2'b10
  } tmrso_mode_e;

  // software-visible state
  tmrso_mode_e mode_r;
  logic [15:0] mstp_r;
  logic [7:0] tctl_r [2];
  logic [7:0] tca_r [2];
  logic [7:0] tcb_r [2];
  logic [2:0] flag_r [2];
  logic [2:0] seen_r [2];
  logic adc_trigger_enable_r;
  logic [3:0] osel_r [2];

  // count sources
  logic [PRE_W-1:0] pre_r;
  logic [2:0] ext_r;
  logic [2:0] d_r;

  // output flops
  logic [15:0] rdata_r;
  logic [1:0] tout_r;
  logic adc_r;
  logic [1:0] irqa_r;
  logic [1:0] irqb_r;
  logic [1:0] irqo_r;

  // combinational glue
  logic running;
  logic acc_ok;
  logic ext_rise;
  logic ext_fall;
  logic casc_both;
  logic [2:0] d_now;
  logic [2:0] d_fall;
  logic [1:0] tick;
  logic [1:0] mat_a;
  logic [1:0] mat_b;
  logic [1:0] ovf;
  logic [1:0] cnt_we;
  logic [1:0] tout_w;
  logic [7:0] cnt [2];
  logic [7:0] tsc_rd [2];
  logic [1:0] tsc_hit;

  assign running = (mode_r == TMRSO_RUN);
  assign acc_ok = running; // [R15]

  // module stop state follows the stop bit at the end of each bus cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_r <= TMRSO_STOP; // [R16]
    end else begin
      case (mode_r)
        TMRSO_RUN: begin
          if (mstp_r[BIT_STOP]) begin
            mode_r <= TMRSO_STOP; // [R14]
          end
        end
        TMRSO_STOP: begin
          if (!mstp_r[BIT_STOP]) begin
            mode_r <= TMRSO_RUN; // [R14]
          end
        end
        default: mode_r <= TMRSO_STOP;
      endcase
    end
  end

  // module stop register stays reachable, else the block could never wake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mstp_r <= RST_MSTP; // [R16]
    end else if (wr_stb && addr == ADDR_MSTP_HI) begin
      mstp_r[15:8] <= wdata[7:0];
    end else if (wr_stb && addr == ADDR_MSTP_LO) begin
      mstp_r[7:0] <= wdata[7:0];
    end
  end

  // free-running prescaler; held while stopped to save power
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else if (running) begin
      pre_r <= pre_r + 13'h0001;
    end
  end

  // divided clocks as square waves; count on their falling edges
  always_comb begin
    d_now[0] = pre_r[$clog2(DIV_A)-1]; // [R17]
    d_now[1] = pre_r[$clog2(DIV_B)-1]; // [R17]
    d_now[2] = pre_r[$clog2(DIV_C)-1]; // [R17]
    d_fall = d_r & ~d_now;
  end

  // external input pipeline; the last two stages form the edge detect
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      d_r <= 3'h0;
      ext_r <= 3'h0;
    end else begin
      d_r <= d_now;
      ext_r <= {ext_r[1:0], ext_clk_in};
    end
  end

  // edges are taken from the last two pipeline stages
  assign ext_rise = ext_r[1] && !ext_r[2];
  assign ext_fall = !ext_r[1] && ext_r[2];

  // both channels on cascade would feed each other; no count pulse then
  assign casc_both = (tctl_r[0][2:0] == CKS_CASC) && (tctl_r[1][2:0] == CKS_CASC);

  // status register selected while the timer is awake
  assign tsc_hit[0] = acc_ok && addr == ADDR_TSC0;
  assign tsc_hit[1] = acc_ok && addr == ADDR_TSC1;

  // tick selection per channel; cascade uses the other channel's event
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case (tctl_r[i][2:0]) // [R22]
        CKS_D8: tick[i] = d_fall[0];
        CKS_D64: tick[i] = d_fall[1];
        CKS_D8192: tick[i] = d_fall[2];
        CKS_CASC: tick[i] = !casc_both && ((i == 0) ? ovf[1] : mat_a[0]);
        CKS_EXT_R: tick[i] = ext_rise; // [R18] [R19]
        CKS_EXT_F: tick[i] = ext_fall; // [R18] [R19]
        CKS_EXT_B: tick[i] = ext_rise || ext_fall; // [R18] [R19]
        default: tick[i] = 1'b0;
      endcase
    end
  end

  // counter write strobes
  assign cnt_we[0] = acc_ok && wr_stb && addr == ADDR_CNT0;
  assign cnt_we[1] = acc_ok && wr_stb && addr == ADDR_CNT1;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      tmrso_chan u_chan (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(running),
        .tick(tick[g]),
        .tconst_a(tca_r[g]),
        .tconst_b(tcb_r[g]),
        .cnt_we(cnt_we[g]),
        .cnt_wdata(wdata[7:0]),
        .out_sel(osel_r[g]),
        .timer_count(cnt[g]),
        .match_a(mat_a[g]),
        .match_b(mat_b[g]),
        .ovf_evt(ovf[g]),
        .timer_out(tout_w[g])
      );
    end
  endgenerate

  // control, constant and output-select registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        tctl_r[i] <= RST_ZERO;
        tca_r[i] <= RST_TC;
        tcb_r[i] <= RST_TC;
        osel_r[i] <= 4'h0;
      end
      adc_trigger_enable_r <= 1'b0; // [R7]
    end else if (acc_ok && wr_stb) begin
      case (addr)
        ADDR_TCTL0: tctl_r[0] <= wdata[7:0];
        ADDR_TCTL1: tctl_r[1] <= wdata[7:0];
        ADDR_TCA0: tca_r[0] <= wdata[7:0];
        ADDR_TCA1: tca_r[1] <= wdata[7:0];
        ADDR_TCB0: tcb_r[0] <= wdata[7:0];
        ADDR_TCB1: tcb_r[1] <= wdata[7:0];
        ADDR_TSC0: begin
          adc_trigger_enable_r <= wdata[BIT_ADC_TRIGGER_ENABLE];
          osel_r[0] <= wdata[3:0]; // [R9] [R10]
        end
        ADDR_TSC1: osel_r[1] <= wdata[3:0]; // [R8]
        default: ;
      endcase
    end
  end

  // status flags: per-flag read-armed clear, hardware set wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        flag_r[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic [2:0] set_v;
        logic [2:0] clr_v;
        set_v = {mat_b[i], mat_a[i], ovf[i]};
        clr_v = 3'h0;
        if (tsc_hit[i] && wr_stb) begin
          clr_v = seen_r[i] & ~wdata[BIT_COMPARE_B_FLAG:BIT_OVF]; // [R1] [R3]
        end
        clr_v[2] = clr_v[2] || (dtc_ack_b[i] && !transfer_irq_select[i]); // [R4]
        clr_v[1] = clr_v[1] || (dtc_ack_a[i] && !transfer_irq_select[i]); // [R4]
        flag_r[i] <= set_v | (flag_r[i] & ~clr_v); // [R5] [R6] [R24]
      end
    end
  end

  // read arming; a written 0 clears a flag only after software has seen it set
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        seen_r[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tsc_hit[i] && rd_stb) begin
          seen_r[i] <= flag_r[i]; // [R3]
        end else if (tsc_hit[i] && wr_stb) begin
          seen_r[i] <= 3'h0; // any status write disarms
        end
      end
    end
  end

  // status read images; channel 1 bit 4 is fixed at 1
  assign tsc_rd[0] = {flag_r[0], adc_trigger_enable_r, osel_r[0]}; // [R2]
  assign tsc_rd[1] = {flag_r[1], 1'b1, osel_r[1]}; // [R2] [R8]

  // read data one cycle after the strobe; unmapped reads and timer reads while stopped give 0
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (rd_stb) begin
      rdata_r <= 16'h0000;
      case (addr)
        // stop register answers even while stopped
        ADDR_MSTP_HI: rdata_r <= {8'h00, mstp_r[15:8]};
        ADDR_MSTP_LO: rdata_r <= {8'h00, mstp_r[7:0]};
        default: if (acc_ok) begin // [R15]
          // timer registers go silent in module stop
          case (addr)
            ADDR_TCTL0: rdata_r <= {8'h00, tctl_r[0]};
            ADDR_TCTL1: rdata_r <= {8'h00, tctl_r[1]};
            ADDR_TSC0: rdata_r <= {8'h00, tsc_rd[0]};
            ADDR_TSC1: rdata_r <= {8'h00, tsc_rd[1]};
            ADDR_TCA0: rdata_r <= {8'h00, tca_r[0]};
            ADDR_TCA1: rdata_r <= {8'h00, tca_r[1]};
            ADDR_TCB0: rdata_r <= {8'h00, tcb_r[0]};
            ADDR_TCB1: rdata_r <= {8'h00, tcb_r[1]};
            ADDR_CNT0: rdata_r <= {8'h00, cnt[0]};
            ADDR_CNT1: rdata_r <= {8'h00, cnt[1]};
            default: rdata_r <= 16'h0000;
          endcase
        end
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // registered outputs; requests lag their flag by one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tout_r <= 2'h0;
      adc_r <= 1'b0;
      irqa_r <= 2'h0;
      irqb_r <= 2'h0;
      irqo_r <= 2'h0;
    end else begin
      tout_r <= tout_w;
      adc_r <= mat_a[0] && adc_trigger_enable_r; // [R7] [R25]
      // request follows flag and enable, one cycle late
      for (int i = 0; i < 2; i++) begin
        irqa_r[i] <= flag_r[i][1] && tctl_r[i][BIT_IEA]; // [R23]
        irqb_r[i] <= flag_r[i][2] && tctl_r[i][BIT_IEB]; // [R23]
        irqo_r[i] <= flag_r[i][0] && tctl_r[i][BIT_IEO]; // [R23]
      end
    end
  end

  // every port comes straight from a flop
  assign rdata = rdata_r;
  assign timer_out = tout_r;
  assign adc_start = adc_r;
  assign compare_a_irq = irqa_r;
  assign compare_b_irq = irqb_r;
  assign overflow_irq = irqo_r;
endmodule
`default_nettype wire

// >>> tmrso_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tmrso_asserts
  import tmrso_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic [1:0] dtc_ack_a,
  input wire logic [1:0] dtc_ack_b,
  input wire logic [1:0] timer_out,
  input wire logic adc_start,
  input wire logic [1:0] compare_a_irq,
  input wire logic [1:0] compare_b_irq,
  input wire logic [1:0] overflow_irq
);
  logic stop_r;
  logic stop_d_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadow of the stop bit; delayed copy covers the switch-over edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_r <= 1'b1;
      stop_d_r <= 1'b1;
    end else begin
      if (wr_stb && addr == ADDR_MSTP_HI) begin
        stop_r <= wdata[4];
      end
      stop_d_r <= stop_r;
    end
  end
  a_rdata_only_read: assert property (rdata != 16'h0000 |-> $past(rd_stb))
    else $error("read data outside a read answer");
  a_adc_one_cycle: assert property (adc_start |=> !adc_start)
    else $error("adc start longer than one cycle");
  a_cmpa_irq_hold: assert property (
    $fell(compare_a_irq[0]) |-> $past(wr_stb, 2) || $past(dtc_ack_a[0], 2))
    else $error("match a request dropped without cause");
  a_cmpb_irq_hold: assert property (
    $fell(compare_b_irq[1]) |-> $past(wr_stb, 2) || $past(dtc_ack_b[1], 2))
    else $error("match b request dropped without cause");
  a_ovf_irq_hold: assert property (
    $fell(overflow_irq[1]) |-> $past(wr_stb, 2))
    else $error("overflow request dropped without write");
  a_stop_no_read: assert property (
    rd_stb && addr <= ADDR_CNT1 && stop_r && stop_d_r |=> rdata == 16'h0000)
    else $error("timer register answered while stopped");
  a_ch1_bit_four: assert property (
    rd_stb && addr == ADDR_TSC1 && !stop_r && !stop_d_r |=> rdata[4])
    else $error("channel 1 bit 4 read as 0");
  a_out_reset_low: assert property ($past(rst) |-> timer_out == 2'h0)
    else $error("timer output not low after reset");
  c_adc: cover property ($rose(adc_start));
  c_ovf: cover property ($rose(overflow_irq[1]));
  c_dtc: cover property ($fell(compare_b_irq[1]));
endmodule
bind tmrso_top tmrso_asserts chk_i (.clk_sys, .rst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .dtc_ack_a, .dtc_ack_b, .timer_out, .adc_start, .compare_a_irq,
  .compare_b_irq, .overflow_irq);
`default_nettype wire

// >>> tmrso_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmrso_far_model #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_on,
  input wire logic [1:0] compare_a_irq,
  input wire logic [1:0] compare_b_irq,
  output logic ext_clk_in,
  output logic [1:0] dtc_ack_a,
  output logic [1:0] dtc_ack_b
);
  int cnt_r;
  logic [1:0] a_d_r;
  logic [1:0] b_d_r;
  // count source stands low between runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 0;
      ext_clk_in <= 1'b0;
    end else if (!ext_on) begin
      cnt_r <= 0;
      ext_clk_in <= 1'b0;
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 0;
      ext_clk_in <= !ext_clk_in; // each level held HALF cycles
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // transfer controller serves each new request once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      a_d_r <= 2'h0;
      b_d_r <= 2'h0;
      dtc_ack_a <= 2'h0;
      dtc_ack_b <= 2'h0;
    end else begin
      a_d_r <= compare_a_irq;
      b_d_r <= compare_b_irq;
      dtc_ack_a <= compare_a_irq & ~a_d_r;
      dtc_ack_b <= compare_b_irq & ~b_d_r;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tmrso_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic ext_on = 1'b0;
  logic [1:0] irq_sel = 2'h0;
  logic [15:0] rdata;
  logic ext_clk_in;
  logic [1:0] ack_a;
  logic [1:0] ack_b;
  logic [1:0] timer_out;
  logic adc_start;
  logic [1:0] irq_a;
  logic [1:0] irq_b;
  logic [1:0] irq_o;
  int errors = 0;
  int cmp_count = 0;
  int adc_n = 0;
  tmrso_top uut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_clk_in(ext_clk_in),
    .dtc_ack_a(ack_a), .dtc_ack_b(ack_b), .transfer_irq_select(irq_sel),
    .timer_out(timer_out), .adc_start(adc_start), .compare_a_irq(irq_a),
    .compare_b_irq(irq_b), .overflow_irq(irq_o));
  tmrso_far_model far (.clk_sys(clk_sys), .rst(rst), .ext_on(ext_on),
    .compare_a_irq(irq_a), .compare_b_irq(irq_b), .ext_clk_in(ext_clk_in),
    .dtc_ack_a(ack_a), .dtc_ack_b(ack_b));
  // 25 MHz
  always #20 clk_sys = !clk_sys;
  // count converter start pulses
  always @(posedge clk_sys) begin
    if (adc_start === 1'b1) begin
      adc_n <= adc_n + 1;
    end
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // bounded wait: 0 match a ch0, 1 overflow ch1, 2 match b ch1
  task automatic wait_req(input int sel);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if ((sel == 0 && irq_a[0] === 1'b1) || (sel == 1 && irq_o[1] === 1'b1) ||
          (sel == 2 && irq_b[1] === 1'b1)) break;
    end
    if (i == 400) begin
      errors++;
      $display("unexpected timeout at %0t: sel %h exp %h", $time, sel, 1);
      final_report();
    end
  endtask
  task automatic t_reset_stop;
    rd(ADDR_MSTP_HI, 16'h003F);
    rd(ADDR_MSTP_LO, 16'h00FF);
    wr(ADDR_TSC0, 16'h00FF);
    rd(ADDR_TSC1, 16'h0000);
    wr(ADDR_MSTP_HI, 16'h0000);
    rd(ADDR_TSC0, 16'h0000);
    rd(ADDR_TSC1, 16'h0010);
    wr(ADDR_TSC1, 16'h00EF);
    rd(ADDR_TSC1, 16'h001F);
    $display("test reset_stop done");
  endtask
  // equal constants: toggle on b beats drive-0 on a
  task automatic t_match_ch0;
    irq_sel <= 2'b01; // channel 0 flags wait for the software clear
    wr(ADDR_TCA0, 16'h0003);
    wr(ADDR_TCB0, 16'h0003);
    wr(ADDR_TSC0, 16'h001D);
    wr(ADDR_CNT0, 16'h0000);
    wr(ADDR_TCTL0, {8'h00, 8'h40 | {5'h00, CKS_D8}});
    wait_req(0);
    repeat (2) @(posedge clk_sys);
    chk({14'h0000, timer_out}, 16'h0001);
    chk(16'(adc_n), 16'h0001);
    wr(ADDR_TSC0, 16'h001D);
    rd(ADDR_TSC0, 16'h00DD);
    wr(ADDR_TSC0, 16'h001D);
    rd(ADDR_TSC0, 16'h001D);
    $display("test match_ch0 done");
  endtask
  task automatic t_ovf_ch1;
    wr(ADDR_CNT1, 16'h00FD);
    wr(ADDR_TCTL1, {8'h00, 8'h20 | {5'h00, CKS_EXT_R}});
    ext_on <= 1'b1;
    wait_req(1);
    rd(ADDR_TSC1, 16'h00FF);
    wr(ADDR_TSC1, 16'h000F);
    rd(ADDR_TSC1, 16'h001F);
    $display("test ovf_ch1 done");
  endtask
  task automatic t_dtc_ch1;
    wr(ADDR_TCTL1, {8'h00, 8'h80 | {5'h00, CKS_EXT_B}});
    wr(ADDR_CNT1, 16'h0000);
    wr(ADDR_TCB1, 16'h0006);
    wr(ADDR_TSC1, 16'h0004);
    wait_req(2);
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, irq_b[1]}, 16'h0000);
    chk({15'h0000, timer_out[1]}, 16'h0000);
    ext_on <= 1'b0;
    rd(ADDR_TSC1, 16'h0014);
    wr(ADDR_MSTP_HI, 16'h0010);
    rd(ADDR_TSC1, 16'h0000);
    $display("test dtc_ch1 done");
  endtask
  initial begin
    #4000000;
    errors++;
    $display("unexpected run timeout at %0t: %h %h", $time, 0, 1);
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_stop();
    t_match_ch0();
    t_ovf_ch1();
    t_dtc_ch1();
    final_report();
  end
endmodule
`default_nettype wire
